// >>> design/fpsup_pkg.sv
// Purpose: Shared constants and types for the fan PWM supervisor.
// Assumes: A single 10 MHz system clock; PWM timing is derived from it.
// Notes:   Timing figures are kept in their own units and converted here.
package fpsup_pkg;

    // System clock rate
    localparam int unsigned CLK_HZ          = 10_000_000;
    // Nominal PWM ramp frequency
    localparam int unsigned PWM_HZ          = 30;
    // Demand and floor level width
    localparam int unsigned LVL_W           = 8;
    // Ramp steps in one PWM cycle
    localparam int unsigned RAMP_STEPS      = 1 << LVL_W;
    // Clocks per ramp step, rounded down so the cycle is never long
    localparam int unsigned STEP_CYC_DEF    = CLK_HZ / (PWM_HZ * RAMP_STEPS);

    // Start-up period in PWM cycles
    localparam int unsigned STARTUP_CYCLES  = 32;
    // Missing-pulse window in PWM cycles
    localparam int unsigned MISS_CYCLES     = 32;
    // Diagnostic period in PWM cycles
    localparam int unsigned DIAG_CYCLES     = 3;
    // Phase counter width, holds up to 31
    localparam int unsigned PH_W            = 5;
    localparam logic [PH_W-1:0] STARTUP_LAST = PH_W'(STARTUP_CYCLES - 1);
    localparam logic [PH_W-1:0] MISS_LAST    = PH_W'(MISS_CYCLES - 1);
    localparam logic [PH_W-1:0] DIAG_LAST    = PH_W'(DIAG_CYCLES - 1);
    localparam logic [PH_W-1:0] PH_ZERO      = 5'h00;

    // Blanking window after the drive switches on, in nanoseconds
    localparam int unsigned BLANK_TIME_NS   = 50_000;
    // Blank count, rounded up, at least one cycle
    localparam int unsigned BLANK_CYC_DEF   =
        (BLANK_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Full-scale level means full drive
    localparam logic [LVL_W-1:0] LVL_FULL   = 8'hff;
    localparam logic [LVL_W-1:0] LVL_ZERO   = 8'h00;

    // Sequencer states
    typedef enum logic [2:0] {
        FPS_SHUT,
        FPS_START1,
        FPS_START2,
        FPS_NORMAL,
        FPS_DIAG,
        FPS_RETRY,
        FPS_FAULT
    } fpsup_state_e;

endpackage

// >>> design/fpsup_top.sv
// Purpose: Start-up, shutdown, missing-pulse and fault sequencer of a PWM fan driver.
// Assumes: Comparator levels arrive as digital levels with hysteresis applied;
//          inputs other than the synchronous reset are asynchronous and pass two flip-flops first.
// Notes:   Phase and missing-pulse timers count PWM cycle boundaries made by the internal ramp; blanking counts clocks.
`timescale 1ns/1ps
module fpsup_top #(
    parameter int unsigned STEP_CYC  = fpsup_pkg::STEP_CYC_DEF,  // Clocks per ramp step
    parameter int unsigned BLANK_CYC = fpsup_pkg::BLANK_CYC_DEF  // Blank window in clocks
) (
    input  wire logic                       MCLK_IN,          // System clock
    input  wire logic                       RESET_IN,         // Sync reset, high
    input  wire logic                       SHDN_REQ_IN,      // Floor below off_threshold
    input  wire logic                       WAKE_IN,          // Floor above wake_threshold
    input  wire logic                       OVERHEAT_IN,      // Demand above overheat_threshold
    input  wire logic                       SENSE_IN,         // Commutation pulse train
    input  wire logic [fpsup_pkg::LVL_W-1:0] TEMP_DEMAND_IN,  // temp_demand_level
    input  wire logic [fpsup_pkg::LVL_W-1:0] FLOOR_LEVEL_IN,  // floor_level
    output logic                            FAN_DRIVE_OUT,    // fan_drive switch
    output logic                            ALARM_N_OUT,      // Alarm pin data, always low
    output logic                            ALARM_OE_N_OUT    // Alarm pull-down, low = active
);
    import fpsup_pkg::*;

    // Checks below all run on this clock and stop during reset
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RESET_IN);

    // Counter widths follow the parameters
    localparam int unsigned STEP_W  = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
    localparam int unsigned BLANK_W = $clog2(BLANK_CYC + 1);
    localparam logic [STEP_W-1:0]  STEP_LAST  = STEP_W'(STEP_CYC - 1);
    localparam logic [STEP_W-1:0]  STEP_ZERO  = '0;
    localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_CYC);
    localparam logic [BLANK_W-1:0] BLANK_ZERO = '0;

    // All state of the block in one record
    typedef struct packed {
        fpsup_state_e        st;          // Sequencer state
        logic [1:0]          shdn_sync;   // Shutdown request synchroniser
        logic [1:0]          wake_sync;   // Release synchroniser
        logic [1:0]          ovh_sync;    // Overheat synchroniser
        logic [2:0]          sense_sync;  // Sense sync plus edge history
        logic [LVL_W-1:0]    dem_s1;      // Demand word, first stage
        logic [LVL_W-1:0]    dem_s2;      // Demand word, second stage
        logic [LVL_W-1:0]    flr_s1;      // Floor word, first stage
        logic [LVL_W-1:0]    flr_s2;      // Floor word, second stage
        logic [LVL_W-1:0]    dem_s3;      // Demand word, agreement stage
        logic [LVL_W-1:0]    flr_s3;      // Floor word, agreement stage
        logic [LVL_W-1:0]    dem_q;       // Demand word, settled copy
        logic [LVL_W-1:0]    flr_q;       // Floor word, settled copy
        logic [STEP_W-1:0]   step;        // Clocks within a ramp step
        logic [LVL_W-1:0]    ramp;        // Ramp position within PWM cycle
        logic [PH_W-1:0]     phase;       // Cycles in start-up or diagnostic
        logic [PH_W-1:0]     miss;        // Pulse-free cycles in normal loop
        logic [BLANK_W-1:0]  blank;       // Blanking countdown
        logic                drive;       // Registered fan switch
        logic                alarm_oe_n;  // Registered alarm enable, low = pulled
    } fpsup_state_s;

    localparam fpsup_state_s RESET_STATE = '{
        st:         FPS_SHUT,
        shdn_sync:  2'h0,
        wake_sync:  2'h0,
        ovh_sync:   2'h0,
        sense_sync: 3'h0,
        dem_s1:     LVL_ZERO,
        dem_s2:     LVL_ZERO,
        flr_s1:     LVL_ZERO,
        flr_s2:     LVL_ZERO,
        dem_s3:     LVL_ZERO,
        flr_s3:     LVL_ZERO,
        dem_q:      LVL_ZERO,
        flr_q:      LVL_ZERO,
        step:       STEP_ZERO,
        ramp:       LVL_ZERO,
        phase:      PH_ZERO,
        miss:       PH_ZERO,
        blank:      BLANK_ZERO,
        drive:      1'b0,
        alarm_oe_n: 1'b1
    };

    fpsup_state_s s;          // Current state
    fpsup_state_s n;          // Next state
    logic         cycle_end;  // Last clock of a PWM cycle
    logic         pulse_ok;   // Unblanked commutation pulse
    logic         shdn;       // Synchronised shutdown request
    logic         duty_on;    // PWM compare result
    logic         drive_d;    // Next fan switch value
    logic         alarm_d;    // Next alarm activity

    // Larger of two levels
    function automatic logic [LVL_W-1:0] fpsup_max(input logic [LVL_W-1:0] a,
                                                   input logic [LVL_W-1:0] b);
        fpsup_max = (a > b) ? a : b;
    endfunction

    // Next-state logic
    always_comb begin
        n = s;
        // Synchronisers: the first stage feeds only the second
        n.shdn_sync  = {s.shdn_sync[0], SHDN_REQ_IN};
        n.wake_sync  = {s.wake_sync[0], WAKE_IN};
        n.ovh_sync   = {s.ovh_sync[0], OVERHEAT_IN};
        n.sense_sync = {s.sense_sync[1:0], SENSE_IN};
        // Level words: two stages, then taken only when two samples agree,
        // so a word caught in mid-change never reaches the compare
        n.dem_s1     = TEMP_DEMAND_IN;
        n.dem_s2     = s.dem_s1;
        n.dem_s3     = s.dem_s2;
        n.flr_s1     = FLOOR_LEVEL_IN;
        n.flr_s2     = s.flr_s1;
        n.flr_s3     = s.flr_s2;
        if (s.dem_s2 == s.dem_s3) begin
            n.dem_q = s.dem_s2;
        end
        if (s.flr_s2 == s.flr_s3) begin
            n.flr_q = s.flr_s2;
        end

        shdn      = s.shdn_sync[1];
        cycle_end = (s.step == STEP_LAST) && (s.ramp == LVL_FULL);
        pulse_ok  = s.sense_sync[1] & ~s.sense_sync[2] & (s.blank == BLANK_ZERO);
        duty_on   = (s.ramp < fpsup_max(s.dem_q, s.flr_q)) ||
                    (fpsup_max(s.dem_q, s.flr_q) == LVL_FULL);

        if (s.step == STEP_LAST) begin
            n.step = STEP_ZERO;
            n.ramp = s.ramp + 1'b1;
        end else begin
            n.step = s.step + 1'b1;
        end

        // Sequencer
        unique case (s.st)
            FPS_SHUT: begin
                // Ramp held so the first start-up cycle is whole
                n.step = STEP_ZERO;
                n.ramp = LVL_ZERO;
                if (s.wake_sync[1] && !shdn) begin
                    n.st    = FPS_START1;
                    n.phase = PH_ZERO;
                end
            end
            FPS_START1, FPS_START2: begin
                if (pulse_ok) begin
                    n.st   = FPS_NORMAL;
                    n.miss = PH_ZERO;
                end else if (cycle_end) begin
                    n.phase = s.phase + 1'b1;
                    if (s.phase == STARTUP_LAST) begin
                        n.phase = PH_ZERO;
                        n.st    = (s.st == FPS_START1) ? FPS_START2 : FPS_FAULT;
                    end
                end
            end
            FPS_NORMAL: begin
                if (pulse_ok) begin
                    n.miss = PH_ZERO;
                end else if (cycle_end) begin
                    n.miss = s.miss + 1'b1;
                    if (s.miss == MISS_LAST) begin
                        n.miss  = PH_ZERO;
                        n.phase = PH_ZERO;
                        n.st    = FPS_DIAG;
                    end
                end
            end
            FPS_DIAG: begin
                if (pulse_ok) begin
                    n.st   = FPS_NORMAL;
                    n.miss = PH_ZERO;
                end else if (cycle_end) begin
                    n.phase = s.phase + 1'b1;
                    if (s.phase == DIAG_LAST) begin
                        n.phase = PH_ZERO;
                        n.st    = FPS_RETRY;
                    end
                end
            end
            FPS_RETRY: begin
                if (pulse_ok) begin
                    n.st   = FPS_NORMAL;
                    n.miss = PH_ZERO;
                end else if (cycle_end) begin
                    n.phase = s.phase + 1'b1;
                    if (s.phase == STARTUP_LAST) begin
                        n.phase = PH_ZERO;
                        n.st    = FPS_FAULT;
                    end
                end
            end
            FPS_FAULT: begin
                n.st = FPS_FAULT;
            end
            default: begin
                // Illegal code recovers through shutdown
                n.st = FPS_SHUT;
            end
        endcase

        // Fan switch per state
        unique case (s.st)
            FPS_START1, FPS_START2, FPS_DIAG, FPS_RETRY: drive_d = 1'b1;
            FPS_NORMAL: drive_d = duty_on;
            default:    drive_d = 1'b0;
        endcase
        // overheat alarm only in normal loop
        alarm_d = (s.st == FPS_FAULT) || ((s.st == FPS_NORMAL) && s.ovh_sync[1]);

        if (shdn) begin
            n.st    = FPS_SHUT;
            n.step  = STEP_ZERO;
            n.ramp  = LVL_ZERO;
            n.phase = PH_ZERO;
            n.miss  = PH_ZERO;
            drive_d = 1'b0;
            alarm_d = 1'b0;
        end

        n.drive      = drive_d;
        n.alarm_oe_n = ~alarm_d;
        // Blank restarts on each drive turn-on edge
        if (drive_d && !s.drive) begin
            n.blank = BLANK_LOAD;
        end else if (s.blank != BLANK_ZERO) begin
            n.blank = s.blank - 1'b1;
        end
    end

    // State register
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            s <= RESET_STATE;
        end else begin
            s <= n;
        end
    end

    // Drive and alarm enable come straight from the record; alarm data is tied low
    assign FAN_DRIVE_OUT  = s.drive;
    assign ALARM_OE_N_OUT = s.alarm_oe_n;
    assign ALARM_N_OUT    = 1'b0;

    // Silent last cycle of a timed phase
    sequence silent_end(logic [PH_W-1:0] last);
        cycle_end && !pulse_ok && !shdn && (s.phase == last);
    endsequence

    // Fan forced on during timed phases
    sequence forced_on;
        s.st inside {FPS_START1, FPS_START2, FPS_DIAG, FPS_RETRY} && !shdn;
    endsequence

    forced_drive_a: assert property (forced_on |=> FAN_DRIVE_OUT)
        else $error("Drive not held on during timed phase");

    // first silent start-up goes to second
    start_retry_a: assert property (
        (s.st == FPS_START1) and silent_end(STARTUP_LAST) |=> s.st == FPS_START2)
        else $error("First start-up did not repeat");

    start_fault_a: assert property (
        (s.st == FPS_START2) and silent_end(STARTUP_LAST) |=> s.st == FPS_FAULT)
        else $error("Second start-up did not fault");

    // shutdown drops alarm and drive next edge
    shdn_outputs_a: assert property (
        shdn |=> ALARM_OE_N_OUT && !FAN_DRIVE_OUT)
        else $error("Shutdown left alarm or drive active");

    // shutdown clears counters, waits in idle
    shdn_reset_a: assert property (
        shdn ##1 shdn |-> s.st == FPS_SHUT && s.phase == PH_ZERO && s.miss == PH_ZERO)
        else $error("Shutdown did not reset state");

    miss_expire_a: assert property (
        (s.st == FPS_NORMAL) && cycle_end && !pulse_ok && !shdn && (s.miss == MISS_LAST)
        |=> s.st == FPS_DIAG ##1 (FAN_DRIVE_OUT || $past(shdn)))
        else $error("Missing-pulse expiry not handled");

    diag_retry_a: assert property (
        (s.st == FPS_DIAG) and silent_end(DIAG_LAST) |=> s.st == FPS_RETRY)
        else $error("Silent diagnostic did not retry");

    pulse_clear_a: assert property (
        (s.st == FPS_NORMAL) && pulse_ok && !shdn |=> s.miss == PH_ZERO)
        else $error("Pulse did not clear missing counter");

    // fault keeps alarm low and fan off
    fault_hold_a: assert property (
        (s.st == FPS_FAULT) && !shdn |=> !ALARM_OE_N_OUT && !FAN_DRIVE_OUT
            && $stable(s.st))
        else $error("Fault state not held");

    // overheat alarm tracks level in normal loop
    overheat_alarm_a: assert property (
        (s.st == FPS_NORMAL) && !shdn |=> ALARM_OE_N_OUT == !$past(s.ovh_sync[1]))
        else $error("Overheat alarm mismatch");

    blank_ignore_a: assert property (
        (s.blank != BLANK_ZERO) |-> !pulse_ok)
        else $error("Blanked pulse accepted");

    // idle holds until wake without shutdown
    idle_hold_a: assert property (
        (s.st == FPS_SHUT) && !(s.wake_sync[1] && !shdn) |=> s.st == FPS_SHUT)
        else $error("Left idle without release");

    // release starts a whole first start-up cycle
    wake_start_a: assert property (
        (s.st == FPS_SHUT) && s.wake_sync[1] && !shdn
        |=> (s.st == FPS_START1) && (s.ramp == LVL_ZERO) && (s.phase == PH_ZERO))
        else $error("Release did not restart start-up");

    // full-scale level keeps the fan on
    full_duty_a: assert property (
        (s.st == FPS_NORMAL) && !shdn && (s.dem_q == LVL_FULL) |=> FAN_DRIVE_OUT)
        else $error("Full demand did not hold drive on");

endmodule // fpsup_top

// >>> sim/fpsup_fan_model.sv
// Purpose: Behavioural brushless fan on the far side of the drive switch.
// Assumes: Commutation only chops current while the fan is energised.
// Notes:   A stalled fan gives no pulses at all; the bench commands stalls.
`timescale 1ns/1ps
module fpsup_fan_model #(
    parameter int unsigned PULSE_GAP = 200,  // Energised clocks per commutation
    parameter int unsigned PULSE_LEN = 4     // Sense pulse width in clocks
) (
    input  wire logic clk_in,    // System clock
    input  wire logic rst_in,    // Reset, high
    input  wire logic drive_in,  // Fan switch from the supervisor
    input  wire logic spin_in,   // High = rotor free, low = stalled
    output logic      sense_out  // Commutation pulse train
);
    int unsigned acc_q;  // Energised clocks since last commutation
    int unsigned hi_q;   // Remaining pulse clocks

    // Pulses only while driven, so low duty starves the detector as real fans do
    always @(posedge clk_in) begin
        if (rst_in) begin
            acc_q     <= 0;
            hi_q      <= 0;
            sense_out <= 1'b0;
        end else begin
            if (spin_in && drive_in) begin
                acc_q <= (acc_q == PULSE_GAP - 1) ? 0 : acc_q + 1;
            end
            if (spin_in && drive_in && acc_q == PULSE_GAP - 1) begin
                hi_q <= PULSE_LEN;
            end else if (hi_q != 0) begin
                hi_q <= hi_q - 1;
            end
            sense_out <= (hi_q != 0);
        end
    end
endmodule // fpsup_fan_model

// >>> sim/fan_pwm_supervisor_test.sv
// Purpose: Self-checking bench for the fan PWM supervisor.
// Assumes: STEP_CYC 1 so one PWM cycle is 256 clocks; blank window 4 clocks.
// Notes:   Expected duty and timings come from integer models below.
`timescale 1ns/1ps
module fan_pwm_supervisor_test;
    import fpsup_pkg::*;
    localparam int PWM = 256;          // Clocks per PWM cycle at STEP_CYC 1
    logic             clk;             // System clock
    logic             rst;             // Reset, high
    logic             shdn, wake, hot; // Comparator levels
    logic             spin;            // Fan free to rotate
    logic             sense;           // Fan pulses
    logic             drive, alarm_n, alarm_oe_n;
    logic [LVL_W-1:0] demand, floor_lvl;
    int               n_fail, n_checks, t, c, i, a, b;
    int               duty_q[$];       // Expected duties, in order

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    fpsup_top #(.STEP_CYC(1), .BLANK_CYC(4)) dut (
        .MCLK_IN(clk), .RESET_IN(rst), .SHDN_REQ_IN(shdn), .WAKE_IN(wake),
        .OVERHEAT_IN(hot), .SENSE_IN(sense), .TEMP_DEMAND_IN(demand),
        .FLOOR_LEVEL_IN(floor_lvl), .FAN_DRIVE_OUT(drive), .ALARM_N_OUT(alarm_n),
        .ALARM_OE_N_OUT(alarm_oe_n));

    fpsup_fan_model #(.PULSE_GAP(200), .PULSE_LEN(4)) fan (
        .clk_in(clk), .rst_in(rst), .drive_in(drive), .spin_in(spin), .sense_out(sense));

    // Verdict in one place
    task automatic stop_test;
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Bounded wait for a drive level, clocks spent returned
    task automatic wait_drive(input logic v, input int bound, output int n);
        n = 0;
        while (drive !== v && n < bound) begin
            @(negedge clk);
            n++;
        end
        if (drive !== v) begin
            check(drive, v);
            stop_test();
        end
    endtask

    // Drive-on clocks over one whole ramp period equal the duty
    task automatic count_on(output int n);
        n = 0;
        repeat (PWM) begin
            @(negedge clk);
            if (drive === 1'b1) n++;
        end
    endtask

    initial begin
        rst = 1'b1; shdn = 1'b0; wake = 1'b0; hot = 1'b0; spin = 1'b0;
        demand = 8'h00; floor_lvl = 8'h40;
        void'($urandom(77793));
        cyc(6);
        rst = 1'b0;
        // Idle until wake; shutdown holds it idle even with wake
        cyc(300);
        check(drive, 1'b0);
        check(alarm_n, 1'b0);
        shdn = 1'b1; wake = 1'b1;
        cyc(300);
        check({drive, alarm_oe_n}, 2'b01);
        // Stalled fan: two full start-up periods, then latched fault
        shdn = 1'b0;
        wait_drive(1'b1, 8, t);
        cyc(32 * PWM - 20);
        check(drive, 1'b1);
        cyc(40);
        check({drive, alarm_oe_n}, 2'b11);
        cyc(32 * PWM - 60);
        check(drive, 1'b1);
        wait_drive(1'b0, 80, t);
        cyc(2);
        check(alarm_oe_n, 1'b0);
        demand = 8'hff;
        cyc(1000);
        check({drive, alarm_oe_n}, 2'b00);
        // Shutdown clears the fault and overrides full demand
        shdn = 1'b1;
        cyc(4);
        check({drive, alarm_oe_n}, 2'b01);
        cyc(600);
        check({drive, alarm_oe_n}, 2'b01);
        // Release restarts like power-up, with a healthy fan
        spin = 1'b1;
        shdn = 1'b0;
        wait_drive(1'b1, 8, t);
        check(t <= 6, 1);
        // Duty follows the larger level; last entry is full scale
        for (i = 0; i < 6; i++) begin
            a = (i == 5) ? 255 : $urandom_range(254, 16);
            b = $urandom_range(254, 16);
            demand = a[7:0];
            floor_lvl = b[7:0];
            duty_q.push_back((a == 255) ? 256 : ((a > b) ? a : b));
            cyc(3 * PWM);
            count_on(c);
            check(c, duty_q.pop_front());
        end
        // Overheat alarm tracks its level while the fan runs
        demand = 8'h80; floor_lvl = 8'h40; hot = 1'b1;
        cyc(3 * PWM);
        check(alarm_oe_n, 1'b0);
        count_on(c);
        check(c, 32'h80);
        hot = 1'b0;
        cyc(6);
        check(alarm_oe_n, 1'b1);
        // Zero duty starves pulses: diagnostic after the silent window
        demand = 8'h00; floor_lvl = 8'h00;
        // Let the zero level pass the input stages so drive has settled low
        cyc(8);
        wait_drive(1'b1, 34 * PWM, t);
        check(t >= 29 * PWM, 1);
        // Fan rotor position carries over, so the pulse may come early
        wait_drive(1'b0, 3 * PWM, t);
        check(t >= 6 && t <= 210, 1);
        wait_drive(1'b1, 34 * PWM, t);
        check(t >= 31 * PWM && t <= 33 * PWM, 1);
        // Stall in diagnostic: three cycles plus one start-up, then fault
        spin = 1'b0;
        wait_drive(1'b0, 36 * PWM, t);
        check(t >= 35 * PWM - 16 && t <= 35 * PWM + 16, 1);
        cyc(2);
        check(alarm_oe_n, 1'b0);
        // Power cycling clears the fault as well, then power-up runs
        rst = 1'b1;
        cyc(3);
        check({drive, alarm_oe_n}, 2'b01);
        spin = 1'b1;
        rst = 1'b0;
        wait_drive(1'b1, 8, t);
        check(t <= 6, 1);
        // Shutdown from normal running clears drive and alarm
        demand = 8'hff; hot = 1'b1;
        cyc(3 * PWM);
        check({drive, alarm_oe_n}, 2'b10);
        shdn = 1'b1;
        cyc(4);
        check({drive, alarm_oe_n}, 2'b01);
        cyc(PWM);
        check({drive, alarm_oe_n}, 2'b01);
        stop_test();
    end
endmodule // fan_pwm_supervisor_test
